// File: rtl/sxcr_config.sv
`timescale 1ns/100ps
`include "sxcr_regs.svh"
// configuration register and the static controls it drives
module sxcr_config (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // host port
    input wire logic config_load_strobe_n_in,
    input wire logic [15:0] data_in,
    input wire logic parity_ctrl_gate_n_in,
    // word boundaries from the datapaths
    input wire logic tx_word_start_in,
    input wire logic rx_word_start_in,
    // serial loop
    input wire logic tx_serial_in,
    input wire logic line1_in,
    input wire logic line2_in,
    input wire sxcr_pkg::sxcr_rxw_s rx1_word_in,
    input wire sxcr_pkg::sxcr_rxw_s rx2_word_in,
    // decoded outputs
    output sxcr_pkg::sxcr_cfg_s cfg_out,
    output logic parity_insert_out,
    output logic [6:0] tx_div_out,
    output logic [6:0] rx_div_out,
    output logic [5:0] tx_wlen_out,
    output logic [5:0] rx_wlen_out,
    output logic rx1_serial_out,
    output logic rx2_serial_out,
    output logic tx_drive_en_out,
    output logic rx1_accept_out,
    output logic rx2_accept_out
);
    import sxcr_pkg::*;

    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    logic rst_meta_r; // first stage, read only by second
    logic rst_n_r; // released reset used everywhere
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // checks arm one cycle after release, so that the output flops
    // already hold decoded values and not their reset zeros
    logic chk_en_r; // assertions armed
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            chk_en_r <= 1'b0;
        end else begin
            chk_en_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    // note: this reset is power-up only; the device master reset is not
    // wired here so it never disturbs the held value
    logic [15:0] cfg_r; // stored control word
    logic [15:0] cfg_nxt; // next control word
    // the data port is one 16-bit host half wide; serial words move as two halves
    always_comb begin
        cfg_nxt = cfg_r; // hold until next strobe
        if (!config_load_strobe_n_in) begin
            cfg_nxt = data_in & `SXCR_USED_MASK;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_r <= `SXCR_RESET_VAL;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ----------------------------------------
    // word length shadows, latched at word starts
    // ----------------------------------------
    logic tx_wl_r; // word length used by transmitter
    logic tx_wl_nxt;
    logic rx_wl_r; // word length used by receivers
    logic rx_wl_nxt;
    always_comb begin
        tx_wl_nxt = tx_word_start_in ? cfg_r[`SXCR_WLEN_BIT] : tx_wl_r;
        rx_wl_nxt = rx_word_start_in ? cfg_r[`SXCR_WLEN_BIT] : rx_wl_r;
    end
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tx_wl_r <= 1'(`SXCR_RESET_VAL >> `SXCR_WLEN_BIT);
            rx_wl_r <= 1'(`SXCR_RESET_VAL >> `SXCR_WLEN_BIT);
        end else begin
            tx_wl_r <= tx_wl_nxt;
            rx_wl_r <= rx_wl_nxt;
        end
    end

    // ----------------------------------------
    // source/destination checkers
    // ----------------------------------------
    logic acc1; // receiver 1 accept
    logic acc2; // receiver 2 accept
    sxcr_sd_check u_sd1 (
        .en_in(cfg_r[`SXCR_SD1_EN_BIT]),
        .code9_in(cfg_r[`SXCR_SD1_X_BIT]),
        .code10_in(cfg_r[`SXCR_SD1_Y_BIT]),
        .word_in(rx1_word_in),
        .accept_out(acc1)
    );
    sxcr_sd_check u_sd2 (
        .en_in(cfg_r[`SXCR_SD2_EN_BIT]),
        .code9_in(cfg_r[`SXCR_SD2_X_BIT]),
        .code10_in(cfg_r[`SXCR_SD2_Y_BIT]),
        .word_in(rx2_word_in),
        .accept_out(acc2)
    );

    // ----------------------------------------
    // shared decodes
    // ----------------------------------------
    // rate bit to divisor; one decode so both directions always agree
    function automatic logic [6:0] rate_div(input logic slow);
        rate_div = slow ? `SXCR_DIV_SLOW : `SXCR_DIV_FAST;
    endfunction : rate_div
    // length bit to bits per word
    function automatic logic [5:0] word_bits(input logic short_word);
        word_bits = short_word ? `SXCR_WLEN_SHORT : `SXCR_WLEN_LONG;
    endfunction : word_bits

    // ----------------------------------------
    // registered decoded outputs
    // ----------------------------------------
    typedef struct packed {
        logic par;
        logic [6:0] txd;
        logic [6:0] rxd;
        logic [5:0] txw;
        logic [5:0] rxw;
        logic s1;
        logic s2;
        logic a1;
        logic a2;
        logic drv; // transmitter drive enable
    } sxcr_out_s;
    sxcr_out_s out_r; // output flops
    sxcr_out_s out_nxt;
    logic wrap; // wrap test active
    always_comb begin
        wrap = !cfg_r[`SXCR_WRAP_N_BIT];
        // open gate reads high via pull-up; high forces parity
        out_nxt.par = parity_ctrl_gate_n_in | cfg_r[`SXCR_PAR_INS_BIT];
        out_nxt.txd = rate_div(cfg_r[`SXCR_TX_RATE_BIT]);
        out_nxt.rxd = rate_div(cfg_r[`SXCR_RX_RATE_BIT]);
        out_nxt.txw = word_bits(tx_wl_r);
        out_nxt.rxw = word_bits(rx_wl_r);
        out_nxt.s1 = wrap ? tx_serial_in : line1_in;
        out_nxt.s2 = wrap ? !tx_serial_in : line2_in;
        out_nxt.a1 = acc1;
        out_nxt.a2 = acc2;
        // drivers stay on whatever the wrap bit says
        out_nxt.drv = 1'b1;
    end
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // ----------------------------------------
    // output assignment
    // ----------------------------------------
    always_comb begin
        cfg_out = sxcr_cfg_s'(cfg_r[15:4]); // parity sense passes in field
        parity_insert_out = out_r.par;
        tx_div_out = out_r.txd;
        rx_div_out = out_r.rxd;
        tx_wlen_out = out_r.txw;
        rx_wlen_out = out_r.rxw;
        rx1_serial_out = out_r.s1;
        rx2_serial_out = out_r.s2;
        tx_drive_en_out = out_r.drv; // drivers never silenced in test
        rx1_accept_out = out_r.a1;
        rx2_accept_out = out_r.a2;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!chk_en_r);
    sequence load_seq; !config_load_strobe_n_in; endsequence
    load_capture_a: assert property (load_seq |=> cfg_r == ($past(data_in) & 16'hFFF0))
        else $error("config not captured");
    low_nibble_a: assert property (cfg_r[3:0] == 4'h0)
        else $error("ignored bits stored");
    hold_value_a: assert property (config_load_strobe_n_in |=> $stable(cfg_r))
        else $error("config changed without strobe");
    parity_gate_a: assert property (##1 parity_insert_out ==
        ($past(parity_ctrl_gate_n_in) | $past(cfg_r[4])))
        else $error("parity insert wrong");
    wrap_invert_a: assert property (!cfg_r[5] |=> rx2_serial_out == !$past(tx_serial_in))
        else $error("receiver 2 not inverted");
    wrap_route_a: assert property (!cfg_r[5] |=> rx1_serial_out == $past(tx_serial_in))
        else $error("receiver 1 not looped");
    tx_rate_a: assert property (cfg_r[13] |=> tx_div_out == 7'h50)
        else $error("tx slow rate wrong");
    rx_rate_a: assert property (!cfg_r[14] |=> rx_div_out == 7'h0A)
        else $error("rx fast rate wrong");
    sd_match_a: assert property (cfg_r[6] && rx1_word_in.framed && rx1_word_in.bit9 != cfg_r[7]
        |=> !rx1_accept_out)
        else $error("mismatch accepted");
    wlen_wait_a: assert property (!tx_word_start_in |=> tx_wl_r == $past(tx_wl_r))
        else $error("word length changed mid word");
    sd2_match_a: assert property (cfg_r[9] && rx2_word_in.framed && rx2_word_in.bit10 != cfg_r[11]
        |=> !rx2_accept_out)
        else $error("receiver 2 mismatch accepted");
    sd_off_a: assert property (!cfg_r[6] && rx1_word_in.framed |=> rx1_accept_out)
        else $error("unchecked word refused");
    rx_wlen_wait_a: assert property (!rx_word_start_in |=> rx_wl_r == $past(rx_wl_r))
        else $error("receive length changed mid word");
    wrap_drive_a: assert property (wrap |=> tx_drive_en_out)
        else $error("transmitter silenced in test");
endmodule : sxcr_config

// File: rtl/sxcr_pkg.sv
package sxcr_pkg;
    // decoded configuration carried to the datapaths
    typedef struct packed {
        logic word_length_select;
        logic rx_rate_select;
        logic tx_rate_select;
        logic tx_parity_sense;
        logic second_rx_code_bit10;
        logic second_rx_code_bit9;
        logic second_rx_sd_check_en;
        logic first_rx_code_bit10;
        logic first_rx_code_bit9;
        logic first_rx_sd_check_en;
        logic wrap_test_n;
        logic tx_parity_insert_en;
    } sxcr_cfg_s;
    // per-receiver accept decision inputs
    typedef struct packed {
        logic framed;
        logic bit9;
        logic bit10;
    } sxcr_rxw_s;
endpackage : sxcr_pkg

// File: rtl/sxcr_regs.svh
`ifndef SXCR_REGS_SVH
`define SXCR_REGS_SVH
// Operation
// - load strobe low captures data port
// - bits 0 to 3 ignored
// - gate high forces parity, else bit 4
// - bit 5 low enables wrap test
// - receiver 2 sees inverted loop data
// - transmitter outputs stay active in test
// - bit 6 enables receiver 1 code check
// - receiver 1 compares bits 9,10 to 7,8
// - receiver 2 check bit 9, codes 10,11
// - bit 12 low odd, high even parity
// - bit 13 tx rate divide 10 or 80
// - bit 14 selects receiver rate
// - bit 15 selects 32 or 25 bits
// - length change applies at next word
// - serial word moves as two halves
// - master reset leaves configuration unchanged
// - parity gate pulled up, low obeys bit 4

// ----------------------------------------
// field positions
// ----------------------------------------
`define SXCR_PAR_INS_BIT 4
`define SXCR_WRAP_N_BIT 5
`define SXCR_SD1_EN_BIT 6
`define SXCR_SD1_X_BIT 7
`define SXCR_SD1_Y_BIT 8
`define SXCR_SD2_EN_BIT 9
`define SXCR_SD2_X_BIT 10
`define SXCR_SD2_Y_BIT 11
`define SXCR_PAR_SENSE_BIT 12
`define SXCR_TX_RATE_BIT 13
`define SXCR_RX_RATE_BIT 14
`define SXCR_WLEN_BIT 15
`define SXCR_USED_MASK 16'hFFF0
// power-up value: arbitrary plain default
`define SXCR_RESET_VAL 16'h0020
// ----------------------------------------
// rate divisors and word lengths
// ----------------------------------------
`define SXCR_DIV_FAST 7'h0A
`define SXCR_DIV_SLOW 7'h50
`define SXCR_WLEN_LONG 6'h20
`define SXCR_WLEN_SHORT 6'h19
`endif

// File: rtl/sxcr_sd_check.sv
`timescale 1ns/100ps
// source/destination code compare for one receiver
module sxcr_sd_check (
    // configuration
    input wire logic en_in,
    input wire logic code9_in,
    input wire logic code10_in,
    // received word
    input wire sxcr_pkg::sxcr_rxw_s word_in,
    // result
    output logic accept_out
);
    import sxcr_pkg::*;
    // check disabled accepts any framed word, else needs full match
    always_comb begin
        accept_out = word_in.framed &&
            (!en_in || (word_in.bit9 == code9_in && word_in.bit10 == code10_in));
    end
endmodule : sxcr_sd_check

// File: sim/sxcr_host_model.sv
`timescale 1ns/100ps
// host side: load strobe, data port and parity gate
module sxcr_host_model (
    // clock
    input wire logic clk_in,
    // host port
    output logic strobe_n_out,
    output logic [15:0] data_out,
    output logic gate_n_out
);
    // idle: strobe high, gate at its pulled-up level
    initial begin
        strobe_n_out = 1'b1;
        data_out = 16'h0000;
        gate_n_out = 1'b1;
    end
    // no serial traffic runs, so every code, rate or wrap change lands in a quiet window
    // hold keeps the strobe low so the next call loads back to back
    task automatic load(input logic [15:0] v, input logic g, input logic hold);
        @(negedge clk_in);
        strobe_n_out = 1'b0;
        data_out = v;
        gate_n_out = g;
        if (!hold) begin
            @(negedge clk_in);
            strobe_n_out = 1'b1;
            // data no longer qualified: show the inverse, not the stale value
            data_out = ~v;
        end
    endtask : load
endmodule : sxcr_host_model

// File: sim/tb_top.sv
`timescale 1ns/100ps
// configuration register bench
module tb_top;
    import sxcr_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic tx_ws = 1'b0, rx_ws = 1'b0, tx_s = 1'b0, l1 = 1'b0, l2 = 1'b0;
    logic stb_n, gate_n, par, drv, r1s, r2s, a1, a2;
    logic [15:0] data;
    sxcr_rxw_s w1 = 3'h0, w2 = 3'h0;
    sxcr_cfg_s cfg;
    logic [6:0] txd, rxd;
    logic [5:0] txw, rxw;
    int fails = 0, checked = 0;
    always #12.5 clk_in = ~clk_in;
    sxcr_host_model i_host (.clk_in(clk_in), .strobe_n_out(stb_n), .data_out(data), .gate_n_out(gate_n));
    sxcr_config i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .config_load_strobe_n_in(stb_n), .data_in(data),
        .parity_ctrl_gate_n_in(gate_n), .tx_word_start_in(tx_ws), .rx_word_start_in(rx_ws), .tx_serial_in(tx_s),
        .line1_in(l1), .line2_in(l2), .rx1_word_in(w1), .rx2_word_in(w2), .cfg_out(cfg), .parity_insert_out(par),
        .tx_div_out(txd), .rx_div_out(rxd), .tx_wlen_out(txw), .rx_wlen_out(rxw), .rx1_serial_out(r1s),
        .rx2_serial_out(r2s), .tx_drive_en_out(drv), .rx1_accept_out(a1), .rx2_accept_out(a2));
    // compare with case inequality so an unknown never matches a known value
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // one word start pulse on either path, then let the length land
    task automatic pulse(input logic t, input logic r);
        @(negedge clk_in);
        tx_ws = t;
        rx_ws = r;
        @(negedge clk_in);
        tx_ws = 1'b0;
        rx_ws = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask : pulse
    // write one word, vary the loop inputs from it, check every decoded output except the word lengths
    task automatic cfg_test(input logic [15:0] v, input logic g);
        i_host.load(v, g, 1'b0);
        tx_s = v[8];
        l1 = ~v[8];
        l2 = v[9];
        // word fields come from other bits so codes both match and miss
        w1 = {v[12], v[11], v[10]};
        w2 = {v[4], v[8], v[12]};
        repeat (3) @(negedge clk_in);
        check("cfg", {4'h0, cfg}, {4'h0, v[15:4]});
        check("par_ins", {15'h0, par}, {15'h0, g | v[4]});
        check("tx_div", {9'h0, txd}, v[13] ? 16'h0050 : 16'h000A);
        check("rx_div", {9'h0, rxd}, v[14] ? 16'h0050 : 16'h000A);
        check("rx1_ser", {15'h0, r1s}, {15'h0, v[5] ? l1 : tx_s});
        check("rx2_ser", {15'h0, r2s}, {15'h0, v[5] ? l2 : ~tx_s});
        check("tx_drv", {15'h0, drv}, 16'h0001);
        check("rx1_acc", {15'h0, a1}, {15'h0, w1.framed & (~v[6] | (w1.bit9 == v[7] & w1.bit10 == v[8]))});
        check("rx2_acc", {15'h0, a2}, {15'h0, w2.framed & (~v[9] | (w2.bit9 == v[10] & w2.bit10 == v[11]))});
    endtask : cfg_test
    // hang guard, far beyond the fewer than two hundred cycles the tests need
    initial begin
        #(25 * 3000);
        fails++;
        give_verdict();
    end
    initial begin
        repeat (20) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        check("reset_cfg", {4'h0, cfg}, 16'h0002);
        // walking one with low nibble junk and walking zero over the used bits
        for (int i = 4; i < 16; i++) begin
            cfg_test((16'h1 << i) | 16'h000F, i[0]);
            cfg_test(16'hFFF0 ^ (16'h1 << i), ~i[0]);
        end
        // word length waits for the next word boundary on each path
        cfg_test(16'h0020, 1'b1);
        pulse(1'b1, 1'b1);
        check("tx_wlen", {10'h0, txw}, 16'h0020);
        cfg_test(16'h8020, 1'b1);
        check("tx_wlen_old", {10'h0, txw}, 16'h0020);
        pulse(1'b1, 1'b0);
        check("tx_wlen", {10'h0, txw}, 16'h0019);
        check("rx_wlen_old", {10'h0, rxw}, 16'h0020);
        pulse(1'b0, 1'b1);
        check("rx_wlen", {10'h0, rxw}, 16'h0019);
        // back to back loads: the last wins, then the value holds
        i_host.load(16'h1230, 1'b0, 1'b1);
        i_host.load(16'h4560, 1'b0, 1'b0);
        repeat (6) @(negedge clk_in);
        check("b2b_cfg", {4'h0, cfg}, 16'h0456);
        give_verdict();
    end
endmodule : tb_top
